/* File: rtl/mcs_contactor_ctrl.sv */
// motor contactor start/stop control with contactor status supervision
//
// Function
// - stop input off opens both contactor relays.
// - all starts ignored while stop input is off.
// - energized start input closes its relay when start is allowed.
// - any trip opens both contactor relays.
// - primary start works for every starter type.
// - secondary start only for reversing and two-speed starters.
// - starts are pulses, or held levels in two-wire mode.
// - serial link may also issue primary and secondary starts.
// - enabled isolator check trips while isolator reads open.
// - isolator trip clears by itself once isolator closes.
// - isolator check is configurable and off by default.
// - two contactor status inputs, one per contactor.
// - no status change after start reports open control circuit.
// - no status change after stop reports welded contactor.
// - each discrepancy raises an alarm and is readable.
// - outside energizing seals in the relay, external start flag.
// - outside de-energizing drops the relay, external stop flag.
// - switch reads closed when its terminal carries voltage.
// - ten programmable switches, each mapped to one function.
// - running only while a relay is closed and status agrees.
`timescale 1ns/1ns
`default_nettype none
module mcs_contactor_ctrl
  import mcs_pkg::*;
#(
  parameter int MS_CYC = 100000
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic stop_pin,
  input wire logic start_a_pin,
  input wire logic start_b_pin,
  input wire logic iso_pin,
  input wire logic stat_a_pin,
  input wire logic stat_b_pin,
  input wire logic [9:0] prog_pin,
  input wire logic ser_start_a,
  input wire logic ser_start_b,
  input wire logic ext_trip,
  input wire logic cfg_wr,
  input wire logic cfg_two_wire,
  input wire logic cfg_iso_en,
  input wire mcs_starter_t cfg_starter,
  input wire logic [7:0] cfg_window,
  input wire logic [29:0] cfg_prog_func,
  output logic relay_a,
  output logic relay_b,
  output logic iso_trip,
  output logic [1:0] open_ctrl,
  output logic [1:0] welded,
  output logic [1:0] ext_start_msg,
  output logic [1:0] ext_stop_msg,
  output logic alarm,
  output logic running,
  output logic stopped,
  output logic [9:0] sw_closed,
  output logic [5:0] sw_func
);
`include "mcs_params.svh"

  localparam logic [`MCS_DIV_W-1:0] DIV_LAST = `MCS_DIV_W'(MS_CYC - 1);

  // the tick divider must fit its counter
  if (MS_CYC < 1 || MS_CYC > (1 << `MCS_DIV_W))
    $error("MS_CYC out of range for the tick divider");

  typedef struct packed {
    logic [1:0] relay;
    logic [1:0][`MCS_WIN_W-1:0] tmr;
    logic [1:0] open_ctrl;
    logic [1:0] welded;
    logic [1:0] ext_start;
    logic [1:0] ext_stop;
    logic [1:0] start_prev;
    logic [1:0] stat_prev;
    logic iso_trip;
    logic running;
    logic stopped;
    logic alarm;
    logic [9:0] sw_closed;
    logic [5:0] func;
    logic two_wire;
    logic iso_en;
    mcs_starter_t starter;
    logic [`MCS_WIN_W-1:0] window;
    logic [`MCS_DIV_W-1:0] div;
    logic tick;
  } mcs_state_t;

  mcs_state_t s;
  mcs_state_t next_s;
  mcs_sw_if sw ();

  logic b_ok;
  logic trip_any;
  logic [1:0] ser_start;
  logic [1:0] cmd_chg;
  logic [1:0] chk;

  //////////////////////////////////////////////////////////////////////////////
  // maps each closed programmable switch onto its function line
  function automatic logic [5:0] func_of(input logic [29:0] cfg, input logic [9:0] closed);
    logic [5:0] f;
    mcs_func_t sel;
    f = '0;
    for (int i = 0; i < `MCS_NUM_PROG; i++)
    begin
      sel = mcs_func_t'(cfg[i*`MCS_FUNC_W +: `MCS_FUNC_W]);
      if (closed[i] && sel != MCS_FN_NONE && sel <= MCS_FN_TEST)
        f[3'(sel) - 3'h1] = 1'b1;
    end
    return f;
  endfunction : func_of

  // a zero window still waits one tick so the check never fires at once
  function automatic logic [7:0] win_load(input logic [7:0] w);
    return (w == 8'h00) ? 8'h01 : w;
  endfunction : win_load

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  mcs_sync u_sync (
    .core_clk (core_clk),
    .rst_n (rst_n),
    .stop_pin (stop_pin),
    .start_pin ({start_b_pin, start_a_pin}),
    .iso_pin (iso_pin),
    .stat_pin ({stat_b_pin, stat_a_pin}),
    .prog_pin (prog_pin),
    .sw (sw.src)
  );

  // secondary contactor exists only for reversing and two-speed starters
  assign b_ok = (s.starter == MCS_ST_REV) || (s.starter == MCS_ST_2SPD);
  assign trip_any = ext_trip || s.iso_trip;
  assign ser_start = {ser_start_b, ser_start_a};

  //////////////////////////////////////////////////////////////////////////////
  // next state: configuration, tick, relays, supervision and indicators
  always_comb
  begin
    next_s = s;
    cmd_chg = '0;
    chk = '0;

    // configuration copy, loaded by strobe, factory values at reset
    if (cfg_wr)
    begin
      next_s.two_wire = cfg_two_wire;
      next_s.iso_en = cfg_iso_en;
      next_s.starter = cfg_starter;
      next_s.window = cfg_window;
    end

    // millisecond enable pulse
    next_s.tick = (s.div == DIV_LAST);
    next_s.div = (s.div == DIV_LAST) ? '0 : s.div + `MCS_DIV_W'(1);

    // isolator trip follows the isolator while the check is enabled
    next_s.iso_trip = s.iso_en && !sw.iso;

    for (int i = 0; i < 2; i++)
    begin
      logic allowed;
      logic edge_on;
      logic req_on;
      logic req_off;
      logic kill;
      logic ext_on;
      logic ext_off;
      allowed = (i == `MCS_CON_A) || b_ok;
      edge_on = sw.start[i] && !s.start_prev[i];
      req_on = edge_on || ser_start[i];
      req_off = s.two_wire && s.start_prev[i] && !sw.start[i];
      kill = !sw.stop || trip_any || !allowed;
      ext_on = (s.tmr[i] == '0) && sw.stat[i] && !s.stat_prev[i] && !s.relay[i];
      ext_off = (s.tmr[i] == '0) && !sw.stat[i] && s.stat_prev[i] && s.relay[i];

      next_s.start_prev[i] = sw.start[i];
      next_s.stat_prev[i] = sw.stat[i];

      // relay decision, stop and trip first, then starts, then outside events
      if (kill)
      begin
        next_s.relay[i] = 1'b0;
        cmd_chg[i] = s.relay[i];
      end
      else if (req_on)
      begin
        next_s.relay[i] = 1'b1;
        cmd_chg[i] = !s.relay[i];
      end
      else if (req_off)
      begin
        next_s.relay[i] = 1'b0;
        cmd_chg[i] = s.relay[i];
      end
      else if (ext_on)
      begin
        next_s.relay[i] = 1'b1;
        next_s.ext_start[i] = 1'b1;
        next_s.ext_stop[i] = 1'b0;
      end
      else if (ext_off)
      begin
        next_s.relay[i] = 1'b0;
        next_s.ext_stop[i] = 1'b1;
        next_s.ext_start[i] = 1'b0;
      end

      // a new command restarts the window and clears old messages
      chk[i] = s.tick && (s.tmr[i] == 8'h01) && !cmd_chg[i];
      if (cmd_chg[i])
      begin
        next_s.tmr[i] = win_load(s.window);
        next_s.open_ctrl[i] = 1'b0;
        next_s.welded[i] = 1'b0;
        next_s.ext_start[i] = 1'b0;
        next_s.ext_stop[i] = 1'b0;
      end
      else if (s.tick && s.tmr[i] != '0)
        next_s.tmr[i] = s.tmr[i] - 8'h01;

      // window over: status must now match the command
      if (chk[i] && (sw.stat[i] != s.relay[i]))
      begin
        if (s.relay[i])
          next_s.open_ctrl[i] = 1'b1;
        else
          next_s.welded[i] = 1'b1;
      end
    end

    // indicators and switch functions
    next_s.alarm = |(next_s.open_ctrl | next_s.welded);
    next_s.running = |(s.relay & sw.stat);
    next_s.stopped = (next_s.relay == 2'b00);
    next_s.sw_closed = sw.prog;
    next_s.func = func_of(cfg_prog_func, sw.prog);
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register with factory defaults
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.stopped <= 1'b1;
      s.two_wire <= `MCS_TWO_WIRE_RST;
      s.iso_en <= `MCS_ISO_EN_RST;
      s.starter <= mcs_starter_t'(`MCS_STARTER_RST);
      s.window <= `MCS_WIN_RST;
    end
    else
      s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign relay_a = s.relay[`MCS_CON_A];
  assign relay_b = s.relay[`MCS_CON_B];
  assign iso_trip = s.iso_trip;
  assign open_ctrl = s.open_ctrl;
  assign welded = s.welded;
  assign ext_start_msg = s.ext_start;
  assign ext_stop_msg = s.ext_stop;
  assign alarm = s.alarm;
  assign running = s.running;
  assign stopped = s.stopped;
  assign sw_closed = s.sw_closed;
  assign sw_func = s.func;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_start_ok;
    sw.stop && !trip_any;
  endsequence

  sequence s_ext_energize;
    sw.stat[0] && !s.stat_prev[0] && !s.relay[0] && s.tmr[0] == 8'h00;
  endsequence

  property p_stop_opens;
    !sw.stop |=> !relay_a && !relay_b;
  endproperty
  a_stop_opens: assert property (p_stop_opens) else $error("relay closed with stop off");

  property p_stop_blocks;
    !sw.stop && (ser_start_a || ser_start_b) |=> !relay_a && !relay_b && stopped;
  endproperty
  a_stop_blocks: assert property (p_stop_blocks) else $error("start taken with stop off");

  property p_start_a;
    s_start_ok ##0 (ser_start_a || (sw.start[0] && !s.start_prev[0])) |=> relay_a && !stopped;
  endproperty
  a_start_a: assert property (p_start_a) else $error("primary start not taken");

  property p_trip_opens;
    trip_any |=> !relay_a && !relay_b;
  endproperty
  a_trip_opens: assert property (p_trip_opens) else $error("relay closed during trip");

  property p_b_only;
    !b_ok |=> !relay_b;
  endproperty
  a_b_only: assert property (p_b_only) else $error("secondary relay on wrong starter");

  property p_two_wire_drop;
    s_start_ok ##0 s.two_wire && s.start_prev[0] && !sw.start[0] && !ser_start_a |=> !relay_a;
  endproperty
  a_two_wire_drop: assert property (p_two_wire_drop) else $error("held start released, relay on");

  property p_iso_trip;
    s.iso_en && !sw.iso |=> iso_trip ##1 (!relay_a || !$past(sw.iso));
  endproperty
  a_iso_trip: assert property (p_iso_trip) else $error("isolator open without trip");

  property p_iso_clear;
    (!s.iso_en || sw.iso) |=> !iso_trip;
  endproperty
  a_iso_clear: assert property (p_iso_clear) else $error("isolator trip did not clear");

  property p_open_ctrl;
    chk[0] && s.relay[0] && !sw.stat[0] |=> open_ctrl[0] && alarm;
  endproperty
  a_open_ctrl: assert property (p_open_ctrl) else $error("open control circuit missed");

  property p_welded;
    chk[0] && !s.relay[0] && sw.stat[0] |=> welded[0] && alarm;
  endproperty
  a_welded: assert property (p_welded) else $error("welded contactor missed");

  property p_alarm;
    alarm == |(open_ctrl | welded);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm does not match discrepancies");

  property p_ext_start;
    s_start_ok ##0 s_ext_energize ##0 !ser_start_a && !sw.start[0] && !s.two_wire
      |=> relay_a && ext_start_msg[0];
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("external start not sealed in");

  property p_window;
    cmd_chg[0] |=> s.tmr[0] != 8'h00 && !open_ctrl[0] && !welded[0];
  endproperty
  a_window: assert property (p_window) else $error("discrepancy before window");

  property p_running;
    running |-> $past(s.relay[0] && sw.stat[0]) || $past(s.relay[1] && sw.stat[1]);
  endproperty
  a_running: assert property (p_running) else $error("running without confirmed relay");

endmodule : mcs_contactor_ctrl
`default_nettype wire

/* File: rtl/mcs_params.svh */
// constants of the motor contactor start/stop logic
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// clock rate and the slow tick used by the confirmation window
`define MCS_CLK_HZ 100000000
`define MCS_TICK_MS 1
`define MCS_TICK_CYC ((`MCS_CLK_HZ / 1000) * `MCS_TICK_MS)
`define MCS_DIV_W 17

// contactor indices inside the two-bit vectors
`define MCS_CON_A 0
`define MCS_CON_B 1

// switch input layout
`define MCS_NUM_PROG 10
`define MCS_FUNC_W 3
`define MCS_NUM_FUNC 6
`define MCS_PIN_W 16

// factory defaults of the configuration copy
`define MCS_WIN_W 8
`define MCS_WIN_RST 8'h64
`define MCS_ISO_EN_RST 1'b0
`define MCS_TWO_WIRE_RST 1'b0
`define MCS_STARTER_RST 4'h0

`endif

/* File: rtl/mcs_pkg.sv */
// types of the motor contactor start/stop logic
package mcs_pkg;

  // starter arrangements the relay can drive
  typedef enum logic [3:0] {
    MCS_ST_FVNR,
    MCS_ST_REV,
    MCS_ST_2SPD,
    MCS_ST_WYE_OPEN,
    MCS_ST_INV,
    MCS_ST_SLIP,
    MCS_ST_AUTOXF,
    MCS_ST_PARTW,
    MCS_ST_WYE_CLOSED
  } mcs_starter_t;

  // functions a programmable switch input may take
  typedef enum logic [2:0] {
    MCS_FN_NONE,
    MCS_FN_SETPT_ACCESS,
    MCS_FN_LOCKOUT_RST,
    MCS_FN_PLANT_ILK,
    MCS_FN_AUTO_START,
    MCS_FN_REMOTE_PERM,
    MCS_FN_TEST
  } mcs_func_t;

endpackage : mcs_pkg

/* File: rtl/mcs_sw_if.sv */
// synchronised switch levels passed from the input stage to the control logic
`timescale 1ns/1ns
`default_nettype none
interface mcs_sw_if;
  logic stop;
  logic [1:0] start;
  logic iso;
  logic [1:0] stat;
  logic [9:0] prog;
  modport src (output stop, output start, output iso, output stat, output prog);
  modport snk (input stop, input start, input iso, input stat, input prog);
endinterface : mcs_sw_if
`default_nettype wire

/* File: rtl/mcs_sync.sv */
// two-stage synchroniser for all opto-isolated switch inputs
`timescale 1ns/1ns
`default_nettype none
module mcs_sync
  import mcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic stop_pin,
  input wire logic [1:0] start_pin,
  input wire logic iso_pin,
  input wire logic [1:0] stat_pin,
  input wire logic [9:0] prog_pin,
  mcs_sw_if.src sw
);
`include "mcs_params.svh"

  typedef struct packed {
    logic [`MCS_PIN_W-1:0] s1;
    logic [`MCS_PIN_W-1:0] s2;
  } mcs_sync_state_t;

  mcs_sync_state_t s;
  mcs_sync_state_t next_s;

  //////////////////////////////////////////////////////////////////////////////
  // first stage only feeds the second; a high pin means voltage present
  always_comb
  begin
    next_s.s1 = {prog_pin, stat_pin, iso_pin, start_pin, stop_pin};
    next_s.s2 = s.s1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  //////////////////////////////////////////////////////////////////////////////
  // closed-switch levels seen by the control logic
  assign sw.stop = s.s2[0];
  assign sw.start = s.s2[2:1];
  assign sw.iso = s.s2[3];
  assign sw.stat = s.s2[5:4];
  assign sw.prog = s.s2[15:6];

endmodule : mcs_sync
`default_nettype wire

/* File: testbench/mcs_contactor_model.sv */
// contactor model whose auxiliary contact can stick open or weld shut
`timescale 1ns/1ns
`default_nettype none
module mcs_contactor_model
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic coil,
  input wire logic [1:0] mode,
  output logic aux
);
  ////////////////////////////////////////////////////////////////////////////
  // aux follows the coil one cycle late; mode 1 holds it open, mode 2 closed
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      aux <= 1'b0;
    else if (mode == 2'h1)
      aux <= 1'b0;
    else if (mode == 2'h2)
      aux <= 1'b1;
    else
      aux <= coil;
  end
endmodule : mcs_contactor_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench of the contactor start/stop control
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import mcs_pkg::*;
;
  typedef struct {mcs_starter_t st; logic stop; logic [1:0] exp;} mcs_row_t;
  logic core_clk, rst_n, stop_pin, start_a_pin, start_b_pin, iso_pin, stat_a_pin, stat_b_pin;
  logic ser_start_a, ser_start_b, ext_trip, cfg_wr, cfg_two_wire, cfg_iso_en;
  logic relay_a, relay_b, iso_trip, alarm, running, stopped;
  logic [1:0] open_ctrl, welded, ext_start_msg, ext_stop_msg, mode_a, mode_b;
  logic [9:0] prog_pin, sw_closed;
  logic [5:0] sw_func;
  logic [7:0] cfg_window;
  logic [29:0] cfg_prog_func;
  mcs_starter_t cfg_starter;
  int fail_count, check_count;
  // serial start on both contactors per starter type; bit 0 = a, bit 1 = b
  mcs_row_t rows [10] = '{'{MCS_ST_FVNR, 1'b1, 2'h1}, '{MCS_ST_REV, 1'b1, 2'h3},
    '{MCS_ST_2SPD, 1'b1, 2'h3}, '{MCS_ST_WYE_OPEN, 1'b1, 2'h1}, '{MCS_ST_INV, 1'b1, 2'h1},
    '{MCS_ST_SLIP, 1'b1, 2'h1}, '{MCS_ST_AUTOXF, 1'b1, 2'h1}, '{MCS_ST_PARTW, 1'b1, 2'h1},
    '{MCS_ST_WYE_CLOSED, 1'b1, 2'h1}, '{MCS_ST_REV, 1'b0, 2'h0}};
  ////////////////////////////////////////////////////////////////////////////
  // clock, design and the two contactors
  always #5 core_clk = ~core_clk;
  mcs_contactor_ctrl #(.MS_CYC(4)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .stop_pin(stop_pin), .start_a_pin(start_a_pin), .start_b_pin(start_b_pin),
    .iso_pin(iso_pin), .stat_a_pin(stat_a_pin), .stat_b_pin(stat_b_pin), .prog_pin(prog_pin),
    .ser_start_a(ser_start_a), .ser_start_b(ser_start_b), .ext_trip(ext_trip),
    .cfg_wr(cfg_wr), .cfg_two_wire(cfg_two_wire), .cfg_iso_en(cfg_iso_en),
    .cfg_starter(cfg_starter), .cfg_window(cfg_window), .cfg_prog_func(cfg_prog_func),
    .relay_a(relay_a), .relay_b(relay_b), .iso_trip(iso_trip), .open_ctrl(open_ctrl),
    .welded(welded), .ext_start_msg(ext_start_msg), .ext_stop_msg(ext_stop_msg),
    .alarm(alarm), .running(running), .stopped(stopped), .sw_closed(sw_closed),
    .sw_func(sw_func));
  mcs_contactor_model i_con_a (.core_clk(core_clk), .rst_n(rst_n), .coil(relay_a),
    .mode(mode_a), .aux(stat_a_pin));
  mcs_contactor_model i_con_b (.core_clk(core_clk), .rst_n(rst_n), .coil(relay_b),
    .mode(mode_b), .aux(stat_b_pin));
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic set_cfg(input mcs_starter_t st, input logic tw, input logic iso);
    @(posedge core_clk);
    cfg_starter <= st;
    cfg_two_wire <= tw;
    cfg_iso_en <= iso;
    cfg_wr <= 1'b1;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask : set_cfg
  task automatic pulse(input logic a, input logic b);
    @(posedge core_clk);
    ser_start_a <= a;
    ser_start_b <= b;
    @(posedge core_clk);
    ser_start_a <= 1'b0;
    ser_start_b <= 1'b0;
    cyc(2);
  endtask : pulse
  task automatic stop_all();
    @(posedge core_clk);
    stop_pin <= 1'b0;
    cyc(4);
    chk(relay_a === 1'b0 && relay_b === 1'b0 && stopped === 1'b1, "stop left a relay on");
    @(posedge core_clk);
    stop_pin <= 1'b1;
    cyc(12);
  endtask : stop_all
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {core_clk, rst_n, stop_pin, start_a_pin, start_b_pin, iso_pin, ser_start_a} = '0;
    {ser_start_b, ext_trip, cfg_wr, cfg_two_wire, cfg_iso_en, mode_a, mode_b} = '0;
    {prog_pin, cfg_prog_func} = '0;
    cfg_window = 8'h02;
    cfg_starter = MCS_ST_FVNR;
    cyc(4);
    chk(stopped === 1'b1 && relay_a === 1'b0 && alarm === 1'b0, "reset outputs wrong");
    @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(6);
    chk(iso_trip === 1'b0, "isolator check on by default");
    foreach (rows[i])
    begin
      set_cfg(rows[i].st, 1'b0, 1'b0);
      stop_pin <= rows[i].stop;
      cyc(4);
      pulse(1'b1, 1'b1);
      chk({relay_b, relay_a} === rows[i].exp, "relays after serial start");
      cyc(12);
      chk(alarm === 1'b0, "alarm with status following relay");
      stop_all();
    end
    // hard-wired momentary start on b
    set_cfg(MCS_ST_REV, 1'b0, 1'b0);
    @(posedge core_clk);
    start_b_pin <= 1'b1;
    cyc(2);
    @(posedge core_clk);
    start_b_pin <= 1'b0;
    cyc(4);
    chk(relay_b === 1'b1, "momentary start not latched");
    stop_all();
    // two-wire start follows the held level
    set_cfg(MCS_ST_FVNR, 1'b1, 1'b0);
    @(posedge core_clk);
    start_a_pin <= 1'b1;
    cyc(4);
    chk(relay_a === 1'b1, "two-wire start ignored");
    @(posedge core_clk);
    start_a_pin <= 1'b0;
    cyc(4);
    chk(relay_a === 1'b0, "two-wire release kept relay");
    cyc(12);
    // trip drops the relay and blocks starts
    set_cfg(MCS_ST_FVNR, 1'b0, 1'b0);
    pulse(1'b1, 1'b0);
    @(posedge core_clk);
    ext_trip <= 1'b1;
    cyc(2);
    chk(relay_a === 1'b0, "trip kept relay on");
    pulse(1'b1, 1'b0);
    chk(relay_a === 1'b0, "start taken during trip");
    @(posedge core_clk);
    ext_trip <= 1'b0;
    cyc(12);
    // isolator open trips, closing clears it without reset
    set_cfg(MCS_ST_FVNR, 1'b0, 1'b1);
    cyc(4);
    chk(iso_trip === 1'b1, "open isolator no trip");
    pulse(1'b1, 1'b0);
    chk(relay_a === 1'b0, "start taken with isolator open");
    @(posedge core_clk);
    iso_pin <= 1'b1;
    cyc(4);
    chk(iso_trip === 1'b0, "isolator trip stuck");
    pulse(1'b1, 1'b0);
    chk(relay_a === 1'b1, "start refused after isolator closed");
    stop_all();
    // contactor never closes: open control circuit after the window
    @(posedge core_clk);
    mode_a <= 2'h1;
    pulse(1'b1, 1'b0);
    chk(open_ctrl === 2'h0 && alarm === 1'b0, "flag before window ended");
    cyc(10);
    chk(open_ctrl === 2'h1 && alarm === 1'b1, "open circuit not flagged");
    chk(running === 1'b0, "running while status disagrees");
    // contactor stays closed after stop: welded
    @(posedge core_clk);
    mode_a <= 2'h2;
    cyc(2);
    @(posedge core_clk);
    stop_pin <= 1'b0;
    cyc(14);
    chk(welded === 2'h1 && alarm === 1'b1, "welded not flagged");
    @(posedge core_clk);
    mode_a <= 2'h0;
    stop_pin <= 1'b1;
    cyc(12);
    // outside start and stop of contactor a
    @(posedge core_clk);
    mode_a <= 2'h2;
    cyc(6);
    chk(relay_a === 1'b1 && ext_start_msg === 2'h1, "external start missed");
    chk(running === 1'b1, "running off with contactor closed");
    @(posedge core_clk);
    mode_a <= 2'h1;
    cyc(6);
    chk(relay_a === 1'b0 && ext_stop_msg === 2'h1, "external stop missed");
    chk(running === 1'b0, "running on with contactor open");
    // switch 3 mapped to the test function
    @(posedge core_clk);
    mode_a <= 2'h0;
    cfg_prog_func <= 30'h00000c00;
    prog_pin <= 10'h008;
    cyc(5);
    chk(sw_closed === 10'h008 && sw_func === 6'h20, "switch function wrong");
    // mid-run reset brings back the factory configuration: isolator check off
    @(posedge core_clk);
    iso_pin <= 1'b0;
    cyc(4);
    chk(iso_trip === 1'b1, "open isolator no trip before reset");
    @(posedge core_clk);
    rst_n <= 1'b0;
    cyc(2);
    chk(stopped === 1'b1 && iso_trip === 1'b0 && alarm === 1'b0, "mid-run reset outputs wrong");
    @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(6);
    chk(iso_trip === 1'b0 && relay_a === 1'b0, "isolator check kept after reset");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
